// ==== rtl/spc_regs.vh ====
/*
  Register map, field positions and reset values of the serial port control block.
  Assumes an 8-bit register port with a 3-bit word address.
*/
`ifndef SPC_REGS_VH
`define SPC_REGS_VH

// register addresses
`define SPC_ADDR_CTRL 3'h0
`define SPC_ADDR_STATUS 3'h1
`define SPC_ADDR_MODE 3'h2
`define SPC_ADDR_CARD 3'h3
`define SPC_ADDR_TXHOLD 3'h4
`define SPC_ADDR_RXHOLD 3'h5
`define SPC_ADDR_RATE 3'h6

// serial_ctrl fields
`define SPC_CTRL_TIE 7
`define SPC_CTRL_RIE 6
`define SPC_CTRL_TE 5
`define SPC_CTRL_RE 4
`define SPC_CTRL_MULTIPROC_WAIT_EN 3
`define SPC_CTRL_TX_END_IRQ_EN 2
`define SPC_CTRL_CKHI 1
`define SPC_CTRL_CKLO 0

// serial_status_reg fields
`define SPC_ST_TX_EMPTY_FLAG 7
`define SPC_ST_RX_FULL_FLAG 6
`define SPC_ST_OVERRUN_FLAG 5
`define SPC_ST_FER 4
`define SPC_ST_PER 3
`define SPC_ST_TEND 2
`define SPC_ST_MPB 1
`define SPC_ST_MPBT 0
`define SPC_ST_CLRMASK 8'hf8

// serial_mode_reg fields
`define SPC_MODE_SYNC 7
`define SPC_MODE_CHR 6
`define SPC_MODE_PE 5
`define SPC_MODE_OE 4
`define SPC_MODE_STOP 3
`define SPC_MODE_MP 2

// card_mode_reg fields
`define SPC_CARD_SEL 0

// reset values
`define SPC_CTRL_RST 8'h00
`define SPC_STATUS_RST 8'h84
`define SPC_MODE_RST 8'h00
`define SPC_CARD_RST 8'h00
`define SPC_TXHOLD_RST 8'hff
`define SPC_RXHOLD_RST 8'h00
`define SPC_RATE_RST 8'hff

// timing counts in 16x sample ticks
`define SPC_PH_LAST 4'hf
`define SPC_PH_MID 4'h7

`endif

// ==== rtl/spc_ctrl.v ====
/*
  Serial port with its control register: transmitter, receiver, flags, clock pin
  control and interrupt request levels.
  Assumes standby comes from logic on sys_clk; rxd_pin and sck_pin come from outside.
*/
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "spc_regs.vh"

module spc_ctrl (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  input wire standby,
  // register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // serial pins
  input wire rxd_pin,
  output wire txd_pin,
  input wire sck_pin,
  output reg sck_drive,
  output reg sck_drive_en,
  // interrupt request levels
  output wire tx_empty_irq,
  output wire rx_full_irq,
  output wire rx_error_irq,
  output wire tx_end_irq
);

  localparam ROLE_GPIO = 2'h0;
  localparam ROLE_OUT = 2'h1;
  localparam ROLE_IN = 2'h2;
  localparam ROLE_FIX = 2'h3;

  // clock pin role from card mode, mode bit and the two clock bits
  function [1:0] sck_role;
    input card;
    input mode7;
    input hi;
    input lo;
    begin
      if (card)
      begin
        if (lo)
          sck_role = ROLE_OUT;
        else if (!mode7)
          sck_role = ROLE_GPIO;
        else
          sck_role = ROLE_FIX;
      end
      else if (hi)
        sck_role = ROLE_IN;
      else if (mode7 || lo)
        sck_role = ROLE_OUT;
      else
        sck_role = ROLE_GPIO;
    end
  endfunction

  // registers
  reg [7:0] serial_ctrl_reg;
  reg [7:0] serial_ctrl_next;
  reg [7:0] serial_status_reg;
  reg [7:0] serial_status_next;
  reg [7:0] seen_reg;
  reg [7:0] seen_next;
  reg [7:0] serial_mode_reg;
  reg [7:0] card_mode_reg;
  reg [7:0] tx_holding_reg;
  reg [7:0] rx_holding_reg;
  reg [7:0] rx_holding_next;
  reg [7:0] rate_reg;
  // clocking
  reg [5:0] pre_reg;
  reg [7:0] rate_cnt_reg;
  reg [3:0] ph_reg;
  reg rxd_s1_reg, rxd_s2_reg;
  reg sck_s1_reg, sck_s2_reg, sck_s3_reg;
  // transmitter
  reg tx_busy_reg;
  reg [11:0] tx_shift_reg;
  reg [3:0] tx_cnt_reg;
  reg [3:0] tx_len_reg;
  reg [3:0] tx_msb_reg;
  reg [11:0] frame;
  reg [3:0] flen;
  reg [3:0] fmsb;
  // receiver
  reg rx_busy_reg;
  reg [3:0] rx_ph_reg;
  reg [3:0] rx_idx_reg;
  reg [11:0] rx_shift_reg;
  reg rx_done_reg;
  reg [7:0] rx_data;
  reg rx_ext;
  reg rx_stop;

  wire clr = !rst_n || standby;
  wire card = card_mode_reg[`SPC_CARD_SEL];
  wire sync = !card && serial_mode_reg[`SPC_MODE_SYNC];
  wire gm = serial_mode_reg[`SPC_MODE_SYNC];
  wire chr7 = !sync && serial_mode_reg[`SPC_MODE_CHR];
  wire mp = !sync && serial_mode_reg[`SPC_MODE_MP];
  wire pe = !sync && !mp && serial_mode_reg[`SPC_MODE_PE];
  wire ext_bit = mp || pe;
  wire stop2 = serial_mode_reg[`SPC_MODE_STOP];
  wire [3:0] nd = chr7 ? 4'h7 : 4'h8;
  wire te = serial_ctrl_reg[`SPC_CTRL_TE];
  wire re = serial_ctrl_reg[`SPC_CTRL_RE];
  wire mp_wait = mp && serial_ctrl_reg[`SPC_CTRL_MULTIPROC_WAIT_EN];
  wire rx_halt = serial_status_reg[`SPC_ST_OVERRUN_FLAG] || serial_status_reg[`SPC_ST_FER] ||
                 serial_status_reg[`SPC_ST_PER];
  wire [1:0] role = sck_role(card, gm, serial_ctrl_reg[`SPC_CTRL_CKHI],
                             serial_ctrl_reg[`SPC_CTRL_CKLO]);
  wire ext_clk = (role == ROLE_IN);
  wire wr_ctrl = reg_wr && (reg_addr == `SPC_ADDR_CTRL);
  wire wr_stat = reg_wr && (reg_addr == `SPC_ADDR_STATUS);
  wire rd_stat = reg_rd && (reg_addr == `SPC_ADDR_STATUS);

  // pin synchronisers; only the second stage and later are read
  always @(posedge sys_clk)
  begin
    if (clr)
    begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
    end
    else
    begin
      rxd_s1_reg <= rxd_pin;
      rxd_s2_reg <= rxd_s1_reg;
      sck_s1_reg <= sck_pin;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
    end
  end

  wire sck_rise = sck_s2_reg && !sck_s3_reg;
  wire sck_fall = !sck_s2_reg && sck_s3_reg;

  // prescaler taps: every 1, 4, 16 or 64 system clocks
  reg pre_hit;
  always @*
  begin
    case (serial_mode_reg[1:0])
      2'h0: pre_hit = 1'b1;
      2'h1: pre_hit = &pre_reg[1:0];
      2'h2: pre_hit = &pre_reg[3:0];
      default: pre_hit = &pre_reg[5:0];
    endcase
  end

  wire div_tick = pre_hit && (rate_cnt_reg == rate_reg);
  // external async clock runs at 16x, so each rising edge is one sample tick
  wire tick16 = ext_clk ? sck_rise : div_tick;
  wire ph_end = tick16 && (ph_reg == `SPC_PH_LAST);
  wire tx_ev = (sync && ext_clk) ? sck_fall : ph_end;
  wire smp_ev = ext_clk ? sck_rise : (tick16 && (ph_reg == `SPC_PH_MID));

  // baud divider and the 16-phase bit counter
  always @(posedge sys_clk)
  begin
    if (clr)
    begin
      pre_reg <= 6'h00;
      rate_cnt_reg <= 8'h00;
      ph_reg <= 4'h0;
    end
    else
    begin
      pre_reg <= pre_reg + 6'h01;
      if (pre_hit)
        rate_cnt_reg <= div_tick ? 8'h00 : rate_cnt_reg + 8'h01;
      if (tick16)
        ph_reg <= ph_reg + 4'h1;
    end
  end

  // clock pin: output clock is one period per 16 ticks, i.e. the bit rate
  always @(posedge sys_clk)
  begin
    if (clr)
    begin
      sck_drive <= 1'b0;
      sck_drive_en <= 1'b0;
    end
    else
    begin
      sck_drive_en <= (role == ROLE_OUT) || (role == ROLE_FIX);
      if (role == ROLE_FIX)
        sck_drive <= serial_ctrl_reg[`SPC_CTRL_CKHI];
      else
        sck_drive <= ph_reg[3];
    end
  end

  // transmit frame image, lsb first: start, data, parity or mp bit, stops
  always @*
  begin
    frame = 12'hfff;
    if (sync)
    begin
      frame[7:0] = tx_holding_reg;
      flen = 4'h8;
      fmsb = 4'h7;
    end
    else
    begin
      frame[0] = 1'b0;
      // 7-bit data leaves bit 8 high for a stop unless parity or mp bit lands there
      frame[8:1] = chr7 ? {1'b1, tx_holding_reg[6:0]} : tx_holding_reg;
      if (mp)
        frame[nd + 4'h1] = serial_status_reg[`SPC_ST_MPBT];
      else if (pe)
        frame[nd + 4'h1] = ^(tx_holding_reg & {!chr7, 7'h7f}) ^ serial_mode_reg[`SPC_MODE_OE];
      flen = 4'h2 + nd + {3'h0, ext_bit} + {3'h0, stop2};
      fmsb = nd;
    end
  end

  // shift register takes the holding register only once software cleared the flag
  wire tx_load = tx_ev && !tx_busy_reg && te && !serial_status_reg[`SPC_ST_TX_EMPTY_FLAG] &&
                 !(sync && rx_halt);
  wire tx_msb_done = tx_ev && tx_busy_reg && (tx_cnt_reg == tx_msb_reg);

  always @(posedge sys_clk)
  begin
    if (clr)
    begin
      tx_busy_reg <= 1'b0;
      tx_shift_reg <= 12'hfff;
      tx_cnt_reg <= 4'h0;
      tx_len_reg <= 4'h0;
      tx_msb_reg <= 4'h0;
    end
    else if (tx_load)
    begin
      tx_busy_reg <= 1'b1;
      tx_shift_reg <= frame;
      tx_cnt_reg <= 4'h0;
      tx_len_reg <= flen;
      tx_msb_reg <= fmsb;
    end
    else if (tx_ev && tx_busy_reg)
    begin
      tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
      if (tx_cnt_reg == tx_len_reg - 4'h1)
        tx_busy_reg <= 1'b0;
    end
  end

  assign txd_pin = tx_shift_reg[0];

  // receiver: async hunts a start bit on 16x ticks, sync samples clock edges
  always @(posedge sys_clk)
  begin
    if (clr)
    begin
      rx_busy_reg <= 1'b0;
      rx_ph_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_shift_reg <= 12'h000;
      rx_done_reg <= 1'b0;
    end
    else
    begin
      rx_done_reg <= 1'b0;
      if (!re || rx_halt)
      begin
        rx_busy_reg <= 1'b0;
        rx_idx_reg <= 4'h0;
      end
      else if (sync)
      begin
        if (smp_ev)
        begin
          rx_shift_reg[rx_idx_reg] <= rxd_s2_reg;
          rx_idx_reg <= (rx_idx_reg == 4'h7) ? 4'h0 : rx_idx_reg + 4'h1;
          rx_done_reg <= (rx_idx_reg == 4'h7);
        end
      end
      else if (tick16)
      begin
        if (!rx_busy_reg)
        begin
          if (!rxd_s2_reg)
          begin
            rx_busy_reg <= 1'b1;
            rx_ph_reg <= 4'h0;
            rx_idx_reg <= 4'h0;
          end
        end
        else
        begin
          rx_ph_reg <= rx_ph_reg + 4'h1;
          if (rx_ph_reg == `SPC_PH_MID)
          begin
            rx_shift_reg[rx_idx_reg] <= rxd_s2_reg;
            rx_idx_reg <= rx_idx_reg + 4'h1;
            // a start bit that is high again at mid-bit was a glitch
            if (rx_idx_reg == 4'h0 && rxd_s2_reg)
              rx_busy_reg <= 1'b0;
            else if (rx_idx_reg == nd + {3'h0, ext_bit} + 4'h1)
            begin
              rx_busy_reg <= 1'b0;
              rx_done_reg <= 1'b1;
            end
          end
        end
      end
    end
  end

  // unpack the received frame; only the first stop bit is checked
  always @*
  begin
    if (sync)
    begin
      rx_data = rx_shift_reg[7:0];
      rx_ext = 1'b0;
      rx_stop = 1'b1;
    end
    else
    begin
      rx_data = rx_shift_reg[8:1] & {!chr7, 7'h7f};
      rx_ext = rx_shift_reg[nd + 4'h1];
      rx_stop = rx_shift_reg[nd + {3'h0, ext_bit} + 4'h1];
    end
  end

  wire rx_par_bad = pe && ((^rx_data ^ rx_ext) != serial_mode_reg[`SPC_MODE_OE]);
  wire rx_mpb_hit = rx_done_reg && mp && rx_ext;
  // while waiting, frames without the multiprocessor bit are dropped whole
  wire rx_accept = rx_done_reg && !(mp_wait && !rx_ext);

  // status and control next values; hardware sets are applied last so they win
  always @*
  begin
    serial_ctrl_next = serial_ctrl_reg;
    serial_status_next = serial_status_reg;
    seen_next = seen_reg;
    rx_holding_next = rx_holding_reg;
    if (wr_ctrl)
      serial_ctrl_next = reg_wdata;
    if (rd_stat)
      seen_next = seen_reg | (serial_status_reg & `SPC_ST_CLRMASK);
    if (wr_stat)
    begin
      // a flag clears only if it was read as one first
      serial_status_next[7:3] = serial_status_reg[7:3] & ~(~reg_wdata[7:3] & seen_reg[7:3]);
      if (!reg_wdata[`SPC_ST_TX_EMPTY_FLAG] && seen_reg[`SPC_ST_TX_EMPTY_FLAG])
        serial_status_next[`SPC_ST_TEND] = 1'b0;
      serial_status_next[`SPC_ST_MPBT] = reg_wdata[`SPC_ST_MPBT];
      seen_next = 8'h00;
    end
    if (tx_load)
    begin
      serial_status_next[`SPC_ST_TX_EMPTY_FLAG] = 1'b1;
      serial_status_next[`SPC_ST_TEND] = 1'b0;
    end
    if (tx_msb_done && serial_status_reg[`SPC_ST_TX_EMPTY_FLAG])
      serial_status_next[`SPC_ST_TEND] = 1'b1;
    if (!te)
      serial_status_next[`SPC_ST_TX_EMPTY_FLAG] = 1'b1;
    if (rx_mpb_hit && mp_wait)
    begin
      serial_ctrl_next[`SPC_CTRL_MULTIPROC_WAIT_EN] = 1'b0;
      serial_status_next[`SPC_ST_MPB] = 1'b1;
    end
    else if (rx_done_reg && mp && !mp_wait)
      serial_status_next[`SPC_ST_MPB] = rx_ext;
    // clearing the receive enable touches none of these flags
    if (rx_accept)
    begin
      if (serial_status_reg[`SPC_ST_RX_FULL_FLAG])
        serial_status_next[`SPC_ST_OVERRUN_FLAG] = 1'b1;
      else if (!rx_stop)
      begin
        serial_status_next[`SPC_ST_FER] = 1'b1;
        rx_holding_next = rx_data;
      end
      else if (rx_par_bad)
      begin
        serial_status_next[`SPC_ST_PER] = 1'b1;
        rx_holding_next = rx_data;
      end
      else
      begin
        serial_status_next[`SPC_ST_RX_FULL_FLAG] = 1'b1;
        rx_holding_next = rx_data;
      end
    end
    // a seen mark means nothing once its flag is zero
    seen_next = seen_next & serial_status_next;
  end

  // register file
  always @(posedge sys_clk)
  begin
    if (clr)
    begin
      serial_ctrl_reg <= `SPC_CTRL_RST;
      serial_status_reg <= `SPC_STATUS_RST;
      seen_reg <= 8'h00;
      serial_mode_reg <= `SPC_MODE_RST;
      card_mode_reg <= `SPC_CARD_RST;
      tx_holding_reg <= `SPC_TXHOLD_RST;
      rx_holding_reg <= `SPC_RXHOLD_RST;
      rate_reg <= `SPC_RATE_RST;
    end
    else
    begin
      serial_ctrl_reg <= serial_ctrl_next;
      serial_status_reg <= serial_status_next;
      seen_reg <= seen_next;
      rx_holding_reg <= rx_holding_next;
      if (reg_wr && reg_addr == `SPC_ADDR_MODE)
        serial_mode_reg <= reg_wdata;
      if (reg_wr && reg_addr == `SPC_ADDR_CARD)
        card_mode_reg <= {7'h00, reg_wdata[`SPC_CARD_SEL]};
      if (reg_wr && reg_addr == `SPC_ADDR_TXHOLD)
        tx_holding_reg <= reg_wdata;
      if (reg_wr && reg_addr == `SPC_ADDR_RATE)
        rate_reg <= reg_wdata;
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always @(posedge sys_clk)
  begin
    if (clr || !reg_rd)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_addr)
        `SPC_ADDR_CTRL: reg_rdata <= serial_ctrl_reg;
        `SPC_ADDR_STATUS: reg_rdata <= serial_status_reg;
        `SPC_ADDR_MODE: reg_rdata <= serial_mode_reg;
        `SPC_ADDR_CARD: reg_rdata <= card_mode_reg;
        `SPC_ADDR_TXHOLD: reg_rdata <= tx_holding_reg;
        `SPC_ADDR_RXHOLD: reg_rdata <= rx_holding_reg;
        `SPC_ADDR_RATE: reg_rdata <= rate_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // request levels follow flag and enable, so clearing either withdraws them
  assign tx_empty_irq = serial_ctrl_reg[`SPC_CTRL_TIE] && serial_status_reg[`SPC_ST_TX_EMPTY_FLAG];
  assign rx_full_irq = serial_ctrl_reg[`SPC_CTRL_RIE] && serial_status_reg[`SPC_ST_RX_FULL_FLAG];
  assign rx_error_irq = serial_ctrl_reg[`SPC_CTRL_RIE] && rx_halt;
  assign tx_end_irq = serial_ctrl_reg[`SPC_CTRL_TX_END_IRQ_EN] && serial_status_reg[`SPC_ST_TEND];

endmodule // spc_ctrl

// ==== sim/spc_ctrl_props.sv ====
/*
  Checker for the serial port control block: interrupt gating, control readback and clock pin role.
  Assumes it is bound to spc_ctrl and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "spc_regs.vh"
module spc_ctrl_props (
  // clock and reset
  input logic sys_clk,
  input logic rst_n,
  input logic standby,
  // register port
  input logic [2:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  // serial pins
  input logic rxd_pin,
  input logic txd_pin,
  input logic sck_pin,
  input logic sck_drive,
  input logic sck_drive_en,
  // interrupt levels
  input logic tx_empty_irq,
  input logic rx_full_irq,
  input logic rx_error_irq,
  input logic tx_end_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] ctrl_reg;
  logic card_reg;
  logic mode7_reg;
  // shadows of software settings; bit 3 may clear itself, so it is never relied on
  always @(posedge sys_clk)
  begin
    if (!rst_n || standby)
    begin
      ctrl_reg <= 8'h00;
      card_reg <= 1'b0;
      mode7_reg <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `SPC_ADDR_CTRL) ctrl_reg <= reg_wdata;
      if (reg_addr == `SPC_ADDR_CARD) card_reg <= reg_wdata[0];
      if (reg_addr == `SPC_ADDR_MODE) mode7_reg <= reg_wdata[7];
    end
  end
  // decoded clock pin role from the shadows
  wire pin_ext = !card_reg && ctrl_reg[1];
  wire pin_gpio = card_reg ? (!mode7_reg && !ctrl_reg[0]) : (!mode7_reg && ctrl_reg[1:0] == 2'b00);
  wire pin_out = card_reg ? ctrl_reg[0] : (!ctrl_reg[1] && (mode7_reg || ctrl_reg[0]));
  wire pin_fixed = card_reg && mode7_reg && !ctrl_reg[0];
  // roles outside standby only: a standby cycle clears the pin before the shadows show it
  wire ext_now = pin_ext && !standby;
  wire gpio_now = pin_gpio && !standby;
  wire out_now = pin_out && !standby;
  wire fix_now = pin_fixed && !standby;
  wire any_irq = tx_empty_irq || rx_full_irq || rx_error_irq || tx_end_irq;
  sequence s_ctrl_wr;
    reg_wr && reg_addr == `SPC_ADDR_CTRL && !standby;
  endsequence
  sequence s_ctrl_rd;
    reg_rd && reg_addr == `SPC_ADDR_CTRL && !standby;
  endsequence
  // a write, one quiet cycle, then a read of the same register
  sequence s_wr_rd;
    s_ctrl_wr ##1 (!reg_wr && !standby) ##1 s_ctrl_rd;
  endsequence
  a_standby_clear: assert property (standby |=> !any_irq)
    else $error("request level left up after standby");
  a_ctrl_readback: assert property (s_wr_rd |=> (reg_rdata & 8'hf7) == ($past(reg_wdata, 3) & 8'hf7))
    else $error("control register read back differs from write");
  a_txe_gate: assert property (!ctrl_reg[7] |-> !tx_empty_irq)
    else $error("transmit-empty request while masked");
  a_rx_gate: assert property (!ctrl_reg[6] |-> !rx_full_irq && !rx_error_irq)
    else $error("receive request while masked");
  a_tend_gate: assert property (!ctrl_reg[2] |-> !tx_end_irq)
    else $error("transmit-end request while masked");
  a_txe_forced: assert property (ctrl_reg[7] && !ctrl_reg[5] && $past(!ctrl_reg[5]) |-> tx_empty_irq)
    else $error("transmit-empty not held with transmitter off");
  a_sck_ext: assert property ($past(ext_now) |-> !sck_drive_en)
    else $error("clock pin driven with external clock chosen");
  a_sck_gpio: assert property ($past(gpio_now) |-> !sck_drive_en)
    else $error("clock pin driven while general purpose");
  a_sck_out: assert property ($past(out_now) |-> sck_drive_en)
    else $error("clock pin not driven as clock output");
  a_sck_fixed: assert property ($past(fix_now) |-> sck_drive_en && sck_drive == $past(ctrl_reg[1]))
    else $error("clock pin fixed level wrong");
endmodule // spc_ctrl_props

// ==== sim/spc_peer.sv ====
/*
  Remote serial device: sends async frames on the receive line, decodes the transmit line, makes an external clock.
  Assumes the block runs at one bit per BIT_NS with no parity and one stop bit.
*/
`timescale 1ns/1ps
module spc_peer #(parameter int BIT_NS = 160, parameter int SCK_NS = 160) (
  // line from the block
  input logic txd_pin,
  // lines into the block
  output logic rxd_pin,
  output logic sck_pin,
  // external clock run control
  input logic sck_on
);
  logic [7:0] got_byte;
  int got_count;
  // idle line high, clock still
  initial
  begin
    rxd_pin = 1'b1;
    sck_pin = 1'b0;
    got_byte = 8'h00;
    got_count = 0;
  end
  // external clock, held low while not wanted; in async use each rising edge is one sixteenth of a bit
  always #(SCK_NS / 2) sck_pin = sck_on ? ~sck_pin : 1'b0;
  // one async frame, lsb first, optional multiprocessor bit, chosen stop level
  task send(input logic [7:0] d, input logic mp_on, input logic multiproc_bit_rx, input logic stop_v);
    int i;
    rxd_pin = 1'b0;
    #(BIT_NS);
    for (i = 0; i < 8; i++)
    begin
      rxd_pin = d[i];
      #(BIT_NS);
    end
    if (mp_on)
    begin
      rxd_pin = multiproc_bit_rx;
      #(BIT_NS);
    end
    rxd_pin = stop_v;
    #(BIT_NS);
    rxd_pin = 1'b1;
    #(2 * BIT_NS);
  endtask
  // sample the start bit and each of the 8 data bits at its middle; the stop bit is not sampled
  always @(negedge txd_pin)
  begin : rx_decode
    int i;
    #(BIT_NS / 2);
    if (txd_pin == 1'b0)
    begin
      for (i = 0; i < 8; i++)
      begin
        #(BIT_NS);
        got_byte[i] = txd_pin;
      end
      #(BIT_NS);
      got_count++;
    end
  end
endmodule // spc_peer

// ==== sim/test_spc_ctrl.sv ====
/*
  Self-checking bench for spc_ctrl: register port, transmit, receive, multiprocessor wait, clock pin roles.
  Assumes the register map in spc_regs.vh and the remote device model spc_peer.
*/
`timescale 1ns/1ps
`include "spc_regs.vh"
module test_spc_ctrl;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic standby = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sck_on = 1'b0;
  wire [7:0] reg_rdata;
  wire rxd_pin, txd_pin, sck_pin, sck_drive, sck_drive_en;
  wire tx_empty_irq, rx_full_irq, rx_error_irq, tx_end_irq;
  wire [3:0] irq_vec = {tx_end_irq, rx_error_irq, rx_full_irq, tx_empty_irq};
  int err_total = 0;
  int checked = 0;
  int seed = 36;
  int n;
  logic [7:0] rv;
  logic [7:0] d;
  int tg;
  logic last_lvl;
  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;
  spc_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .standby(standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
    .sck_pin(sck_pin), .sck_drive(sck_drive), .sck_drive_en(sck_drive_en), .tx_empty_irq(tx_empty_irq),
    .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq), .tx_end_irq(tx_end_irq));
  spc_peer peer (.txd_pin(txd_pin), .rxd_pin(rxd_pin), .sck_pin(sck_pin), .sck_on(sck_on));
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bus tasks are entered right after a rising edge and leave at one
  task wr(input logic [2:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // one quiet edge, so a following write never lowers and raises the strobe at once
    @(posedge sys_clk);
  endtask
  task rd(input logic [2:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
    @(posedge sys_clk);
  endtask
  // level check half a cycle after the last edge, so updates have landed
  task lvl(input int which, input logic exp);
    @(negedge sys_clk);
    chk8({7'h00, irq_vec[which]}, {7'h00, exp});
    @(posedge sys_clk);
  endtask
  // bounded wait for a request level, then confirm it
  task wait_irq(input int which);
    int k;
    for (k = 0; k < 3000 && irq_vec[which] !== 1'b1; k++)
      @(negedge sys_clk);
    @(posedge sys_clk);
    lvl(which, 1'b1);
  endtask
  task wait_frame(input int cnt);
    int k;
    for (k = 0; k < 3000 && peer.got_count < cnt; k++)
      @(posedge sys_clk);
    // a frame that never arrived is a mismatch, not a stale byte to compare
    if (peer.got_count < cnt)
      err_total++;
  endtask
  function automatic logic exp_en(input logic c, input logic m, input logic h, input logic l);
    return c ? (l | m) : (!h & (m | l));
  endfunction
  // main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(`SPC_ADDR_CTRL, rv);
    chk8(rv, `SPC_CTRL_RST);
    rd(`SPC_ADDR_STATUS, rv);
    chk8(rv, `SPC_STATUS_RST);
    for (n = 0; n < 24; n++)
    begin
      d = $random(seed);
      wr(`SPC_ADDR_CTRL, d);
      rd(`SPC_ADDR_CTRL, rv);
      chk8(rv, d);
    end
    standby <= 1'b1;
    @(posedge sys_clk);
    standby <= 1'b0;
    rd(`SPC_ADDR_CTRL, rv);
    chk8(rv, 8'h00);
    // format and bit rate before any enable
    wr(`SPC_ADDR_RATE, 8'h00);
    wr(`SPC_ADDR_MODE, 8'h00);
    d = $random(seed);
    wr(`SPC_ADDR_CTRL, 8'ha0);
    wr(`SPC_ADDR_TXHOLD, d);
    rd(`SPC_ADDR_STATUS, rv);
    wr(`SPC_ADDR_STATUS, 8'h7f);
    wait_frame(1);
    chk8(peer.got_byte, d);
    wait_irq(0);
    wr(`SPC_ADDR_CTRL, 8'h24);
    lvl(0, 1'b0);
    wait_irq(3);
    rd(`SPC_ADDR_STATUS, rv);
    wr(`SPC_ADDR_STATUS, 8'h7f);
    lvl(3, 1'b0);
    wait_frame(2);
    chk8(peer.got_byte, d);
    // transmitter off: software cannot clear the empty flag
    wr(`SPC_ADDR_CTRL, 8'h00);
    rd(`SPC_ADDR_STATUS, rv);
    wr(`SPC_ADDR_STATUS, 8'h7f);
    rd(`SPC_ADDR_STATUS, rv);
    chk8(rv & 8'h80, 8'h80);
    // reception with the wait bit set but no multiprocessor format, then receiver off keeps the flag
    d = $random(seed);
    wr(`SPC_ADDR_CTRL, 8'h58);
    peer.send(d, 1'b0, 1'b0, 1'b1);
    wait_irq(1);
    rd(`SPC_ADDR_RXHOLD, rv);
    chk8(rv, d);
    wr(`SPC_ADDR_CTRL, 8'h40);
    rd(`SPC_ADDR_STATUS, rv);
    chk8(rv & 8'h40, 8'h40);
    wr(`SPC_ADDR_STATUS, 8'hbf);
    lvl(1, 1'b0);
    // stop bit low gives the error request
    wr(`SPC_ADDR_CTRL, 8'h50);
    peer.send(8'h5a, 1'b0, 1'b0, 1'b0);
    wait_irq(2);
    rd(`SPC_ADDR_STATUS, rv);
    wr(`SPC_ADDR_STATUS, 8'hef);
    lvl(2, 1'b0);
    // multiprocessor wait drops frames until one carries the bit
    wr(`SPC_ADDR_MODE, 8'h04);
    wr(`SPC_ADDR_CTRL, 8'h58);
    peer.send(8'h33, 1'b1, 1'b0, 1'b1);
    lvl(1, 1'b0);
    d = $random(seed);
    peer.send(d, 1'b1, 1'b1, 1'b1);
    wait_irq(1);
    rd(`SPC_ADDR_CTRL, rv);
    chk8(rv, 8'h50);
    rd(`SPC_ADDR_STATUS, rv);
    chk8(rv & 8'h02, 8'h02);
    rd(`SPC_ADDR_RXHOLD, rv);
    chk8(rv, d);
    // every clock pin role, with the external clock running
    sck_on <= 1'b1;
    wr(`SPC_ADDR_CTRL, 8'h00);
    for (n = 0; n < 16; n++)
    begin
      wr(`SPC_ADDR_CARD, {7'h00, n[3]});
      wr(`SPC_ADDR_MODE, {n[2], 7'h00});
      wr(`SPC_ADDR_CTRL, {6'h00, n[1:0]});
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk8({7'h00, sck_drive_en}, {7'h00, exp_en(n[3], n[2], n[1], n[0])});
      if (n[3] && n[2] && !n[0])
        chk8({7'h00, sck_drive}, {7'h00, n[1]});
      // async clock output: one period per bit, 16 system clocks at divisor 0 and prescale 1
      if (n == 1)
      begin
        tg = 0;
        repeat (32)
        begin
          last_lvl = sck_drive;
          @(negedge sys_clk);
          if (sck_drive !== last_lvl)
            tg++;
        end
        chk8(tg[7:0], 8'h04);
      end
      @(posedge sys_clk);
    end
    report_and_stop;
  end
  // watchdog for a hung handshake
  initial
  begin
    #(600000);
    err_total++;
    report_and_stop;
  end
endmodule // test_spc_ctrl
bind spc_ctrl spc_ctrl_props u_props (.sys_clk(sys_clk), .rst_n(rst_n), .standby(standby), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_pin(rxd_pin),
  .txd_pin(txd_pin), .sck_pin(sck_pin), .sck_drive(sck_drive), .sck_drive_en(sck_drive_en),
  .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq), .tx_end_irq(tx_end_irq));
